// *** sp_params.svh ***
// Register indices, field positions, reset values and timing counts of serial port 0.
`ifndef SP_PARAMS_SVH
`define SP_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define SP_IDX_SERIAL_CONTROL 8'h98
`define SP_IDX_SERIAL_DATA    8'h99
`define SP_IDX_POWER_CONTROL  8'hA0
`define SP_IDX_BAUD_DIV       8'hA1
`define SP_IDX_ADDR_GIVEN     8'hA2
`define SP_IDX_ADDR_BCAST     8'hA3
`define SP_IDX_INT_STATUS     8'hA4
`define SP_IDX_INT_MASK       8'hA5
`define SP_IDX_LSB            2
`define SP_IDX_MSB            9

// ==========================================================================
// Serial control fields and the power control frame-error select bit
`define SP_SC_MODE_HI         7
`define SP_SC_MODE_LO         6
`define SP_SC_MP              5
`define SP_SC_RX_EN           4
`define SP_SC_TX_NINTH        3
`define SP_SC_RX_NINTH        2
`define SP_SC_TX_DONE         1
`define SP_SC_RX_DONE         0
`define SP_PC_FE_SEL          6

// ==========================================================================
// Interrupt status and mask fields
`define SP_INT_TX             0
`define SP_INT_RX             1
`define SP_INT_FE             2
`define SP_INT_W              3

// ==========================================================================
// Reset values
`define SP_RST_BYTE           8'h00
`define SP_RST_BAUD           16'h0001
`define SP_RST_INT            3'h0

// ==========================================================================
// Timing counts
`define SP_M0_DIV_SLOW        12
`define SP_M0_DIV_FAST        2
`define SP_OVS                16
`define SP_OVS_MID            7
`define SP_M0_BITS            8
`define SP_DATA_BITS          8
`define SP_BITS_8BIT          10
`define SP_BITS_9BIT          11

`endif

// *** sp_pkg.sv ***
// Types shared by the serial port 0 design files.
package sp_pkg;

   // ==========================================================================
   // Operating modes
   typedef enum logic [1:0] {
      SP_MODE_SHIFT  = 2'b00,
      SP_MODE_UART8  = 2'b01,
      SP_MODE_UART9F = 2'b10,
      SP_MODE_UART9V = 2'b11
   } sp_mode_t;

   // ==========================================================================
   // Transmit and receive states
   typedef enum logic [1:0] {
      SP_TX_IDLE  = 2'b00,
      SP_TX_ASYNC = 2'b01,
      SP_TX_SHIFT = 2'b10
   } sp_tx_state_t;

   typedef enum logic [2:0] {
      SP_RX_IDLE  = 3'b000,
      SP_RX_START = 3'b001,
      SP_RX_DATA  = 3'b010,
      SP_RX_STOP  = 3'b011,
      SP_RX_SHIFT = 3'b100
   } sp_rx_state_t;

endpackage

// *** sp_tick_gen.sv ***
// Oversampling tick generator that divides the core clock by a programmable count.
module sp_tick_gen
#(
   parameter int W = 16
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // Control
   input  wire logic         en,
   input  wire logic [W-1:0] div,
   // Tick
   output logic              tick
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         wrap;

   // ==========================================================================
   // Counter
   always_comb
   begin
      wrap    = (cnt_ff >= div - W'(1)) || (div == '0);
      nxt_cnt = wrap ? '0 : cnt_ff + W'(1);
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_ff <= '0;
         tick   <= 1'b0;
      end
      else
      begin
         cnt_ff <= en ? nxt_cnt : '0;
         tick   <= en && wrap;
      end
   end

endmodule

// *** sp_serial_port0.sv ***
// Serial port 0: control register, data buffer, shifters and AHB-Lite register slave.
//
// The implementer's own choice: register access over AHB-Lite.
`include "sp_params.svh"

// Summary of operation
// - With frame-error select set, control bit 7 is a sticky frame error flag.
// - Mode 0 shift clock is core clock over 12, or over 2 with multiproc bit.
// - Mode 1 with multiproc bit needs stop bit one and an address match.
// - Modes 2/3 with multiproc bit need ninth bit one and an address match.
// - Receive enable zero blocks reception; one enables it in modes 1, 2, 3.
// - Mode 0 reception starts only while receive enable is 1 and rx-done is 0.
// - Ninth transmit bit is sent in modes 2 and 3, ignored in modes 0, 1.
// - Received ninth bit, or stop level in mode 1, stored when frame accepted.
// - Tx-done set after 8th bit in mode 0, else after the last data bit.
// - Rx-done set after 8th bit in mode 0, else at stop sample if accepted.
// - Interrupt requested while an enabled status bit (tx done, rx done, frame error) is set; software clears status bits.
// - Data buffer write loads the transmit buffer and starts shifting.
// - Data buffer read returns the receive register, not the transmit buffer.
// - Reset clears the whole control register and the data buffer.
module sp_serial_port0
   import sp_pkg::*;
#(
   parameter int          BAUD_W         = 16,
   parameter logic [15:0] MODE2_TICK_DIV = 16'h0004
)
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Serial line
   input  wire logic        RXD_IN,
   output logic             RXD_OUT,
   output logic             RXD_OE,
   output logic             TXD_OUT,
   // Interrupt
   output logic             IRQ
);

   logic                      acc;
   logic                      wr_pend_ff;
   logic                      rd_pend_ff;
   logic                      map_ff;
   logic [7:0]                idx_ff;
   logic                      wr_en;
   logic [7:0]                wdata;
   logic [7:0]                rd_val;
   logic                      mode_hi_ff;
   logic                      mode_lo_ff;
   logic                      mp_ff;
   logic                      ren_ff;
   logic                      tb8_ff;
   logic                      rb8_ff;
   logic                      ti_ff;
   logic                      ri_ff;
   logic                      fe_ff;
   logic                      fe_sel_ff;
   logic [BAUD_W-1:0]         baud_div_ff;
   logic [7:0]                addr_given_ff;
   logic [7:0]                addr_bcast_ff;
   logic [`SP_INT_W-1:0]      int_st_ff;
   logic [`SP_INT_W-1:0]      int_mask_ff;
   logic [`SP_INT_W-1:0]      int_ev;
   logic [7:0]                tx_buf_ff;
   logic [7:0]                rx_buf_ff;
   logic                      tx_pend_ff;
   sp_mode_t                  mode;
   logic                      nine;
   logic                      tick;
   logic [BAUD_W-1:0]         tick_div;
   sp_tx_state_t              tx_st_ff;
   logic [10:0]               tx_sh_ff;
   logic [3:0]                tx_tc_ff;
   logic [3:0]                tx_bc_ff;
   logic [3:0]                tx_last;
   logic                      tx_go;
   logic                      tx_done_set;
   sp_rx_state_t              rx_st_ff;
   logic [8:0]                rx_sh_ff;
   logic [3:0]                rx_tc_ff;
   logic [3:0]                rx_bc_ff;
   logic                      rxd_prev_ff;
   logic                      rx_smp;
   logic                      nxt_accept;
   logic                      nxt_fe_set;
   logic [7:0]                nxt_rx_data;
   logic                      nxt_rx_nb;
   logic                      m0_active;
   logic                      sclk_ff;
   logic [3:0]                hc_ff;
   logic [3:0]                half_last;
   logic                      m0_edge;
   logic                      m0_rise;
   logic                      m0_fall;

   // ==========================================================================
   // AHB-Lite slave: writes complete with no wait, reads with one wait state
   assign acc   = HSEL && HTRANS[1] && HREADY;
   assign wr_en = wr_pend_ff && map_ff;
   assign wdata = HWDATA[7:0];

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         map_ff     <= 1'b0;
         idx_ff     <= 8'h00;
         HRDATA     <= 32'h00000000;
         HREADYOUT  <= 1'b1;
         HRESP      <= 1'b0;
      end
      else
      begin
         wr_pend_ff <= acc && HWRITE;
         rd_pend_ff <= acc && !HWRITE;
         HRESP      <= 1'b0;
         if (acc)
         begin
            idx_ff <= HADDR[`SP_IDX_MSB:`SP_IDX_LSB];
            map_ff <= (HADDR[31:`SP_IDX_MSB+1] == '0) && (HADDR[`SP_IDX_LSB-1:0] == '0);
         end
         if (acc && !HWRITE)
         begin
            HREADYOUT <= 1'b0;
         end
         else if (rd_pend_ff)
         begin
            HRDATA    <= map_ff ? {24'h000000, rd_val} : 32'h00000000;
            HREADYOUT <= 1'b1;
         end
      end
   end

   always_comb
   begin
      case (idx_ff)
         `SP_IDX_SERIAL_CONTROL: rd_val = {fe_sel_ff ? fe_ff : mode_hi_ff, mode_lo_ff, mp_ff, ren_ff,
                                           tb8_ff, rb8_ff, ti_ff, ri_ff};
         `SP_IDX_SERIAL_DATA:    rd_val = rx_buf_ff;
         `SP_IDX_POWER_CONTROL:  rd_val = {1'b0, fe_sel_ff, 6'h00};
         `SP_IDX_BAUD_DIV:       rd_val = baud_div_ff[7:0];
         `SP_IDX_ADDR_GIVEN:     rd_val = addr_given_ff;
         `SP_IDX_ADDR_BCAST:     rd_val = addr_bcast_ff;
         `SP_IDX_INT_STATUS:     rd_val = {5'h00, int_st_ff};
         `SP_IDX_INT_MASK:       rd_val = {5'h00, int_mask_ff};
         default:                rd_val = 8'h00;
      endcase
   end

   // ==========================================================================
   // Serial control register; hardware sets win over software clears
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         mode_hi_ff <= 1'b0;
         mode_lo_ff <= 1'b0;
         mp_ff      <= 1'b0;
         ren_ff     <= 1'b0;
         tb8_ff     <= 1'b0;
         rb8_ff     <= 1'b0;
         ti_ff      <= 1'b0;
         ri_ff      <= 1'b0;
         fe_ff      <= 1'b0;
      end
      else
      begin
         if (wr_en && idx_ff == `SP_IDX_SERIAL_CONTROL)
         begin
            if (!fe_sel_ff)
            begin
               mode_hi_ff <= wdata[`SP_SC_MODE_HI];
            end
            mode_lo_ff <= wdata[`SP_SC_MODE_LO];
            mp_ff      <= wdata[`SP_SC_MP];
            ren_ff     <= wdata[`SP_SC_RX_EN];
            tb8_ff     <= wdata[`SP_SC_TX_NINTH];
         end
         if (nxt_fe_set)
            fe_ff <= 1'b1;
         else if (wr_en && idx_ff == `SP_IDX_SERIAL_CONTROL && fe_sel_ff)
            fe_ff <= wdata[`SP_SC_MODE_HI];
         if (nxt_accept && mode != SP_MODE_SHIFT)
            rb8_ff <= nxt_rx_nb;
         else if (wr_en && idx_ff == `SP_IDX_SERIAL_CONTROL)
            rb8_ff <= wdata[`SP_SC_RX_NINTH];
         if (tx_done_set)
            ti_ff <= 1'b1;
         else if (wr_en && idx_ff == `SP_IDX_SERIAL_CONTROL)
            ti_ff <= wdata[`SP_SC_TX_DONE];
         if (nxt_accept)
            ri_ff <= 1'b1;
         else if (wr_en && idx_ff == `SP_IDX_SERIAL_CONTROL)
            ri_ff <= wdata[`SP_SC_RX_DONE];
      end
   end

   // ==========================================================================
   // Auxiliary configuration registers
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         fe_sel_ff     <= 1'b0;
         baud_div_ff   <= BAUD_W'(`SP_RST_BAUD);
         addr_given_ff <= `SP_RST_BYTE;
         addr_bcast_ff <= `SP_RST_BYTE;
         int_mask_ff   <= `SP_RST_INT;
      end
      else if (wr_en)
      begin
         case (idx_ff)
            `SP_IDX_POWER_CONTROL: fe_sel_ff     <= wdata[`SP_PC_FE_SEL];
            `SP_IDX_BAUD_DIV:      baud_div_ff   <= BAUD_W'(HWDATA[15:0]);
            `SP_IDX_ADDR_GIVEN:    addr_given_ff <= wdata;
            `SP_IDX_ADDR_BCAST:    addr_bcast_ff <= wdata;
            `SP_IDX_INT_MASK:      int_mask_ff   <= wdata[`SP_INT_W-1:0];
            default:               fe_sel_ff     <= fe_sel_ff;
         endcase
      end
   end

   // ==========================================================================
   // Interrupt status, mask and request
   assign int_ev = {nxt_fe_set, nxt_accept, tx_done_set};

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         int_st_ff <= `SP_RST_INT;
         IRQ       <= 1'b0;
      end
      else
      begin
         if (wr_en && idx_ff == `SP_IDX_INT_STATUS)
            int_st_ff <= (int_st_ff & ~wdata[`SP_INT_W-1:0]) | int_ev;
         else
            int_st_ff <= int_st_ff | int_ev;
         IRQ <= |(int_st_ff & int_mask_ff);
      end
   end

   // ==========================================================================
   // Mode decode and bit-rate ticks
   assign mode     = sp_mode_t'({mode_hi_ff, mode_lo_ff});
   assign nine     = mode_hi_ff;
   assign tick_div = (mode == SP_MODE_UART9F) ? BAUD_W'(MODE2_TICK_DIV) : baud_div_ff;

   sp_tick_gen #(.W(BAUD_W)) u_tick
   (
      .clk    (CORE_CLK),
      .resetn (RESETN),
      .en     (mode != SP_MODE_SHIFT),
      .div    (tick_div),
      .tick   (tick)
   );

   // ==========================================================================
   // Mode 0 shift clock: idles high, half period from the multiprocessor bit
   assign m0_active = (tx_st_ff == SP_TX_SHIFT) || (rx_st_ff == SP_RX_SHIFT);
   assign half_last = mp_ff ? 4'(`SP_M0_DIV_FAST / 2 - 1) : 4'(`SP_M0_DIV_SLOW / 2 - 1);
   assign m0_edge   = m0_active && (hc_ff == half_last);
   assign m0_rise   = m0_edge && !sclk_ff;
   assign m0_fall   = m0_edge && sclk_ff;

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         hc_ff   <= 4'h0;
         sclk_ff <= 1'b1;
      end
      else if (!m0_active)
      begin
         hc_ff   <= 4'h0;
         sclk_ff <= 1'b1;
      end
      else if (m0_edge)
      begin
         hc_ff   <= 4'h0;
         sclk_ff <= !sclk_ff;
      end
      else
      begin
         hc_ff <= hc_ff + 4'h1;
      end
   end

   // ==========================================================================
   // Transmit buffer and start request
   assign tx_go   = (tx_st_ff == SP_TX_IDLE) && tx_pend_ff && (rx_st_ff != SP_RX_SHIFT);
   assign tx_last = nine ? 4'(`SP_BITS_9BIT - 1) : 4'(`SP_BITS_8BIT - 1);

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         tx_buf_ff  <= `SP_RST_BYTE;
         tx_pend_ff <= 1'b0;
      end
      else if (wr_en && idx_ff == `SP_IDX_SERIAL_DATA)
      begin
         tx_buf_ff  <= wdata;
         tx_pend_ff <= 1'b1;
      end
      else if (tx_go)
      begin
         tx_pend_ff <= 1'b0;
      end
   end

   // ==========================================================================
   // Transmit shifter
   assign tx_done_set = ((tx_st_ff == SP_TX_ASYNC) && tick && tx_tc_ff == 4'(`SP_OVS - 1)
                         && tx_bc_ff == tx_last - 4'h1)
                      || ((tx_st_ff == SP_TX_SHIFT) && m0_rise && tx_bc_ff == 4'(`SP_M0_BITS - 1));

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         tx_st_ff <= SP_TX_IDLE;
         tx_sh_ff <= 11'h7FF;
         tx_tc_ff <= 4'h0;
         tx_bc_ff <= 4'h0;
      end
      else
      begin
         case (tx_st_ff)
            SP_TX_IDLE:
            begin
               tx_tc_ff <= 4'h0;
               tx_bc_ff <= 4'h0;
               if (tx_go && mode == SP_MODE_SHIFT)
               begin
                  tx_st_ff <= SP_TX_SHIFT;
                  tx_sh_ff <= {3'h7, tx_buf_ff};
               end
               else if (tx_go)
               begin
                  tx_st_ff <= SP_TX_ASYNC;
                  tx_sh_ff <= {1'b1, nine ? tb8_ff : 1'b1, tx_buf_ff, 1'b0};
               end
            end
            SP_TX_ASYNC:
            begin
               if (tick)
               begin
                  tx_tc_ff <= tx_tc_ff + 4'h1;
                  if (tx_tc_ff == 4'(`SP_OVS - 1))
                  begin
                     tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                     tx_bc_ff <= tx_bc_ff + 4'h1;
                     if (tx_bc_ff == tx_last)
                        tx_st_ff <= SP_TX_IDLE;
                  end
               end
            end
            SP_TX_SHIFT:
            begin
               if (m0_fall && tx_bc_ff != 4'h0)
                  tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
               if (m0_rise)
               begin
                  tx_bc_ff <= tx_bc_ff + 4'h1;
                  if (tx_bc_ff == 4'(`SP_M0_BITS - 1))
                     tx_st_ff <= SP_TX_IDLE;
               end
            end
            default:
            begin
               tx_st_ff <= SP_TX_IDLE;
            end
         endcase
      end
   end

   // ==========================================================================
   // Receive outcome and address filter
   assign rx_smp = tick && rx_tc_ff == 4'(`SP_OVS - 1);

   always_comb
   begin
      nxt_accept  = 1'b0;
      nxt_fe_set  = 1'b0;
      nxt_rx_data = nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
      nxt_rx_nb   = nine ? rx_sh_ff[8] : RXD_IN;
      if (rx_st_ff == SP_RX_STOP && rx_smp)
      begin
         nxt_accept = !mp_ff || (nxt_rx_nb && (nxt_rx_data == addr_given_ff
                                            || nxt_rx_data == addr_bcast_ff));
         nxt_fe_set = fe_sel_ff && !RXD_IN;
      end
      else if (rx_st_ff == SP_RX_SHIFT && m0_rise && rx_bc_ff == 4'(`SP_M0_BITS - 1))
      begin
         nxt_accept  = 1'b1;
         nxt_rx_data = {RXD_IN, rx_sh_ff[8:2]};
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
         rx_buf_ff <= `SP_RST_BYTE;
      else if (nxt_accept)
         rx_buf_ff <= nxt_rx_data;
   end

   // ==========================================================================
   // Receive shifter
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rx_st_ff    <= SP_RX_IDLE;
         rx_sh_ff    <= 9'h000;
         rx_tc_ff    <= 4'h0;
         rx_bc_ff    <= 4'h0;
         rxd_prev_ff <= 1'b1;
      end
      else
      begin
         rxd_prev_ff <= RXD_IN;
         if (!ren_ff)
         begin
            rx_st_ff <= SP_RX_IDLE;
         end
         else
         begin
            case (rx_st_ff)
               SP_RX_IDLE:
               begin
                  rx_tc_ff <= 4'h0;
                  rx_bc_ff <= 4'h0;
                  if (mode == SP_MODE_SHIFT && !ri_ff && tx_st_ff == SP_TX_IDLE && !tx_pend_ff)
                     rx_st_ff <= SP_RX_SHIFT;
                  else if (mode != SP_MODE_SHIFT && rxd_prev_ff && !RXD_IN)
                     rx_st_ff <= SP_RX_START;
               end
               SP_RX_START:
               begin
                  if (tick)
                  begin
                     rx_tc_ff <= rx_tc_ff + 4'h1;
                     if (rx_tc_ff == 4'(`SP_OVS_MID))
                     begin
                        rx_tc_ff <= 4'h0;
                        rx_st_ff <= RXD_IN ? SP_RX_IDLE : SP_RX_DATA;
                     end
                  end
               end
               SP_RX_DATA:
               begin
                  if (tick)
                     rx_tc_ff <= rx_tc_ff + 4'h1;
                  if (rx_smp)
                  begin
                     rx_sh_ff <= {RXD_IN, rx_sh_ff[8:1]};
                     rx_bc_ff <= rx_bc_ff + 4'h1;
                     if (rx_bc_ff == (nine ? 4'(`SP_DATA_BITS) : 4'(`SP_DATA_BITS - 1)))
                        rx_st_ff <= SP_RX_STOP;
                  end
               end
               SP_RX_STOP:
               begin
                  if (tick)
                     rx_tc_ff <= rx_tc_ff + 4'h1;
                  if (rx_smp)
                     rx_st_ff <= SP_RX_IDLE;
               end
               SP_RX_SHIFT:
               begin
                  if (m0_rise)
                  begin
                     rx_sh_ff <= {RXD_IN, rx_sh_ff[8:1]};
                     rx_bc_ff <= rx_bc_ff + 4'h1;
                     if (rx_bc_ff == 4'(`SP_M0_BITS - 1))
                        rx_st_ff <= SP_RX_IDLE;
                  end
               end
               default:
               begin
                  rx_st_ff <= SP_RX_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Line pins: mode 0 drives data on the receive pin and the clock on the transmit pin
   always_ff @(posedge CORE_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         TXD_OUT <= 1'b1;
         RXD_OUT <= 1'b1;
         RXD_OE  <= 1'b0;
      end
      else
      begin
         TXD_OUT <= m0_active ? sclk_ff : (tx_st_ff == SP_TX_ASYNC ? tx_sh_ff[0] : 1'b1);
         RXD_OUT <= tx_sh_ff[0];
         RXD_OE  <= (tx_st_ff == SP_TX_SHIFT);
      end
   end

endmodule

// *** sp_port0_props.sv ***
// Concurrent checks on the bus and line ports of serial port 0.
module sp_port0_props
(
   input wire logic        CORE_CLK,
   input wire logic        RESETN,
   input wire logic        HSEL,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   input wire logic        TXD_OUT,
   input wire logic        RXD_OE
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESETN);
   wire logic rq = HSEL && HTRANS[1] && HREADY;
   wire logic rdq = rq && !HWRITE;
   a_resp_okay: assert property (HRESP == 1'b0) else $error("Bad response.");
   a_read_wait: assert property (rdq |=> !HREADYOUT ##1 HREADYOUT) else $error("Bad read wait.");
   a_write_nowait: assert property (rq && HWRITE |=> HREADYOUT) else $error("Write stalled.");
   a_wait_single: assert property (!HREADYOUT |=> HREADYOUT) else $error("Long wait.");
   a_wait_cause: assert property (!HREADYOUT |-> $past(rdq)) else $error("Stray wait.");
   a_rdata_upper: assert property (HRDATA[31:8] == 24'h0) else $error("Upper bits set.");
   a_rdata_hold: assert property ($changed(HRDATA) |-> HREADYOUT && !$past(HREADYOUT)) else $error("Data moved.");
   a_start_low: assert property ($fell(TXD_OUT) && !RXD_OE |=> !TXD_OUT [*5]) else $error("Short low.");
endmodule

// *** sp_node.sv ***
// Remote serial node that samples frames on the line and sends frames back.
module sp_node
(
   input wire logic line,
   output logic     rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] got;
   // A falling edge marks the start, then each bit is sampled in mid-bit.
   initial
   begin
      rxd = 1'b1;
      forever
      begin
         @(negedge line);
         #85;
         for (int i = 0; i < 10; i++)
            #160 got[i] = line;
      end
   end
   // Frames are sent LSB first, sixteen cycles a bit, the line idling high.
   task send(input logic [8:0] d, input int nb, input logic stop);
      rxd <= 1'b0;
      for (int i = 0; i < nb; i++)
         #160 rxd <= d[i];
      #160 rxd <= stop;
      #160 rxd <= 1'b1;
   endtask
endmodule

// *** tb_serial_port0_control.sv ***
// Self-checking bench for serial port 0 with a remote node on the line.
module tb_serial_port0_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CORE_CLK = 0, RESETN = 0, HSEL = 0, HWRITE = 0;
   logic [1:0]  HTRANS = 0;
   logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, r, d;
   logic        HREADYOUT, HRESP, RXD_IN, RXD_OUT, RXD_OE, TXD_OUT, IRQ;
   int          bad_count = 0, n_checks = 0, seed = 28, sc, n;
   sp_serial_port0 dut_u (.CORE_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
      .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .RXD_IN, .RXD_OUT, .RXD_OE, .TXD_OUT, .IRQ);
   sp_node node_u (.line(TXD_OUT), .rxd(RXD_IN));
   initial forever #5 CORE_CLK = ~CORE_CLK;
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task tmo;
      bad_count++;
      finish_test();
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      bad_count += (s !== e);
      if (s !== e)
         $display("unexpected at %0t: %h %h", $time, s, e);
   endtask
   task bus(input logic w, input logic [7:0] i, input logic [31:0] v);
      int t;
      @(posedge CORE_CLK);
      {HSEL, HTRANS, HWRITE, HADDR} <= {1'b1, 2'b10, w, 22'h0, i, 2'b00};
      for (int k = 0; k < 2; k++)
      begin
         t = 0;
         do
            @(posedge CORE_CLK);
         while (HREADYOUT !== 1'b1 && ++t < 20);
         if (t == 20)
            tmo();
         {HSEL, HTRANS, HWDATA} <= {1'b0, 2'b00, v};
      end
      r = HRDATA;
   endtask
   task rd(input logic [7:0] i, input logic [31:0] e);
      bus(1'b0, i, 0);
      chk(r, e);
   endtask
   task wt(input logic [7:0] m);
      r = 0;
      for (int t = 0; t < 200 && (r[7:0] & m) !== m; t++)
         bus(1'b0, 8'h98, 0);
      if ((r[7:0] & m) !== m)
         tmo();
   endtask
   // Mode 0 transmit: collect the data pin at each rising shift clock and time the rises.
   task m0(input logic [7:0] v, input int per);
      int c, k, q;
      logic p;
      bus(1, 8'h99, v);
      q = 0;
      c = 0;
      p = 1'b1;
      for (k = 0; k < 400 && q < 8; k++)
      begin
         @(posedge CORE_CLK);
         if (TXD_OUT === 1'b1 && p === 1'b0)
         begin
            r = {RXD_OUT, r[31:1]};
            if (q == 0)
            begin
               c = k;
               chk(RXD_OE, 1);
            end
            q++;
         end
         p = TXD_OUT;
      end
      chk(q, 8);
      chk(r[31:24], v);
      chk(k - 1 - c, 7 * per);
   endtask
   initial
   begin
      repeat (5) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      rd(8'h98, 0);
      rd(8'h99, 0);
      rd(8'h10, 0);
      bus(1, 8'hA1, 1);
      sc = 'h50;
      bus(1, 8'h98, sc);
      d = $random(seed) & 'hFF;
      bus(1, 8'h99, d);
      wt(2);
      repeat (20) @(posedge CORE_CLK);
      chk(node_u.got[8:0], {1'b1, d[7:0]});
      rd(8'h98, sc | 2);
      chk(IRQ, 0);
      bus(1, 8'hA5, 1);
      rd(8'h98, sc | 2);
      chk(IRQ, 1);
      bus(1, 8'hA4, 7);
      bus(1, 8'h98, sc);
      chk(IRQ, 0);
      $display("test 1 done");
      d = ~d;
      node_u.send({1'b0, d[7:0]}, 8, 1'b1);
      wt(1);
      rd(8'h99, d[7:0]);
      rd(8'h98, sc | 5);
      bus(1, 8'hA0, 'h40);
      bus(1, 8'h98, sc);
      node_u.send(9'h0C3, 8, 1'b0);
      wt(1);
      rd(8'h98, sc | 'h81);
      bus(1, 8'h98, sc);
      rd(8'h98, sc);
      bus(1, 8'hA0, 0);
      $display("test 2 done");
      bus(1, 8'hA2, 'h5A);
      sc = 'hF0;
      bus(1, 8'h98, sc);
      node_u.send(9'h05A, 9, 1'b1);
      rd(8'h98, sc);
      node_u.send(9'h15A, 9, 1'b1);
      wt(1);
      rd(8'h98, sc | 5);
      rd(8'h99, 'h5A);
      bus(1, 8'h98, sc);
      d = $random(seed) & 'hFF;
      bus(1, 8'h99, d);
      wt(2);
      repeat (20) @(posedge CORE_CLK);
      chk(node_u.got[8:0], {1'b0, d[7:0]});
      $display("test 3 done");
      sc = 'h00;
      bus(1, 8'h98, sc);
      d = $random(seed) & 'hFF;
      m0(d[7:0], 12);
      rd(8'h98, 'h02);
      bus(1, 8'h98, 'h20);
      m0(~d[7:0], 2);
      bus(1, 8'h98, 'h10);
      wt(1);
      rd(8'h99, 'hFF);
      $display("test 4 done");
      sc = 'h88;
      bus(1, 8'h98, sc);
      bus(1, 8'h99, 'hFF);
      n = 0;
      repeat (800)
      begin
         @(posedge CORE_CLK);
         n += (TXD_OUT === 1'b0);
      end
      chk(n > 60 && n <= 64, 1);
      $display("test 5 done");
      finish_test();
   end
endmodule
bind sp_serial_port0 sp_port0_props chk_u (.CORE_CLK, .RESETN, .HSEL, .HTRANS, .HWRITE, .HREADY,
   .HRDATA, .HREADYOUT, .HRESP, .TXD_OUT, .RXD_OE);
